//--- core/ulf_pkg.sv
// Behaviour
// - Format bits 1:0 pick 5, 6, 7 or 8 data bits for transmit and receive.
// - Stop bit 0 sends one stop; set sends 1.5 with 5 bits, else two.
// - Receiver samples only the first stop bit of each character.
// - Parity enable inserts a parity bit after data on transmit, checks it on receive.
// - Parity sense 0 gives odd ones count, 1 gives even, over data plus parity.
// - Fixed parity with enable forces parity bit to inverse of sense bit.
// - Break bit holds serial output at logic 0 until cleared.
// - Break touches only the output pin; transmitter keeps running.
// - Latch select bit steers offsets 0x00/0x04 to divisor or data/enable registers.
// - Line format register reads back every bit last written.
// - Baud generator divides the clock by the divisor giving the 16x tick.
// - Any divisor from 2 to 65535 divides correctly.
// - Divisor held as low and high byte forming one 16-bit value.
// - Writing either divisor byte reloads the baud counter at once.
// - At 3.6864 MHz divisor 24 gives 9600 baud, divisor 2 gives 115200.
// - Data bit 0 goes first on the line, in and out.
// - With latch select set, low byte at 0x00 and high byte at 0x04.
package ulf_pkg;

  typedef struct packed {
    logic dl_sel;
    logic brk;
    logic stick;
    logic even;
    logic par_en;
    logic stop2;
    logic [1:0] wlen;
  } ulf_fmt_t;

  typedef enum logic [2:0] {
    TX_IDLE = 3'b000,
    TX_START = 3'b001,
    TX_DATA = 3'b010,
    TX_PAR = 3'b011,
    TX_STOP = 3'b100
  } ulf_tx_st_t;

  typedef enum logic [2:0] {
    RX_IDLE = 3'b000,
    RX_START = 3'b001,
    RX_DATA = 3'b010,
    RX_PAR = 3'b011,
    RX_STOP = 3'b100
  } ulf_rx_st_t;

  localparam logic [7:0] ADDR_DATA = 8'h00;
  localparam logic [7:0] ADDR_IER = 8'h04;
  localparam logic [7:0] ADDR_LFC = 8'h0c;
  localparam logic [7:0] ADDR_STAT = 8'h14;

  localparam logic [7:0] LFC_RST = 8'h03;
  localparam logic [15:0] DIV_RST = 16'h0002;
  localparam logic [3:0] IER_RST = 4'h0;

  localparam int ST_RDY = 0;
  localparam int ST_PE = 2;
  localparam int ST_FE = 3;
  localparam int ST_THRE = 5;
  localparam int ST_TEMT = 6;

  localparam logic [5:0] TICKS_BIT = 6'h10;
  localparam logic [5:0] TICKS_HALF = 6'h08;
  localparam logic [5:0] TICKS_STOP15 = 6'h18;
  localparam logic [5:0] TICKS_STOP2 = 6'h20;

  function automatic logic [7:0] ulf_mask(input logic [1:0] wlen);
    return 8'hff >> (2'h3 - wlen);
  endfunction

  function automatic logic [2:0] ulf_last_idx(input logic [1:0] wlen);
    return 3'h4 + {1'b0, wlen};
  endfunction

  function automatic logic ulf_parity(input logic [7:0] d, input ulf_fmt_t f);
    if (f.stick)
      return ~f.even;
    return (^(d & ulf_mask(f.wlen))) ^ ~f.even;
  endfunction

endpackage

//--- core/ulf_baud_gen.sv
`timescale 1ns/1ps
module ulf_baud_gen
  import ulf_pkg::*;
#(
  parameter int WIDTH = 16
)
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] divisor,
  input wire logic reload,
  output logic tick
);

  logic [WIDTH-1:0] cnt_ff;
  logic [WIDTH-1:0] nxt_cnt;
  logic tick_ff;
  logic nxt_tick;

  always_comb
  begin
    nxt_tick = 1'b0;
    if (reload)
      nxt_cnt = divisor;
    else if (cnt_ff <= WIDTH'(1))
    begin
      nxt_cnt = divisor;
      nxt_tick = 1'b1;
    end
    else
      nxt_cnt = cnt_ff - WIDTH'(1);
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      cnt_ff <= WIDTH'(DIV_RST);
      tick_ff <= 1'b0;
    end
    else
    begin
      cnt_ff <= nxt_cnt;
      tick_ff <= nxt_tick;
    end
  end

  assign tick = tick_ff;

  property p_reload;
    @(posedge ref_clk) disable iff (rst)
    reload |=> cnt_ff == $past(divisor);
  endproperty
  a_reload: assert property (p_reload) else $error("Counter not reloaded by divisor write");

  sequence s_tick_two;
    tick && cnt_ff == WIDTH'(2) && !reload ##1 !reload;
  endsequence
  property p_div_two;
    @(posedge ref_clk) disable iff (rst)
    s_tick_two |=> tick;
  endproperty
  a_div_two: assert property (p_div_two) else $error("Divide by two period wrong");

  property p_gap;
    @(posedge ref_clk) disable iff (rst)
    tick && cnt_ff > WIDTH'(1) && !reload |=> !tick;
  endproperty
  a_gap: assert property (p_gap) else $error("Tick came too early");

endmodule

//--- core/ulf_uart_core.sv
// Added by the designer: the AHB-Lite register port and the address map.
`timescale 1ns/1ps
module ulf_uart_core
  import ulf_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [7:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic serial_rx_pin,
  output logic serial_tx_pin
);

  // Bus and register state
  ulf_fmt_t lfc_ff;
  ulf_fmt_t nxt_lfc;
  logic [3:0] ier_ff;
  logic [3:0] nxt_ier;
  logic [15:0] div_ff;
  logic [15:0] nxt_div;
  logic [7:0] rbr_ff;
  logic [7:0] nxt_rbr;
  logic rdy_ff;
  logic nxt_rdy;
  logic pe_ff;
  logic nxt_pe;
  logic fe_ff;
  logic nxt_fe;
  logic wr_pend_ff;
  logic nxt_wr_pend;
  logic [7:0] wr_addr_ff;
  logic [7:0] nxt_wr_addr;
  logic [31:0] hrdata_ff;
  logic [31:0] nxt_hrdata;
  logic div_reload;
  logic thr_wr;
  logic rd_take;
  logic [7:0] rd_val;

  // Transmit state
  ulf_tx_st_t tx_st_ff;
  ulf_tx_st_t nxt_tx_st;
  ulf_fmt_t tx_fmt_ff;
  ulf_fmt_t nxt_tx_fmt;
  logic [7:0] thr_ff;
  logic [7:0] nxt_thr;
  logic thr_full_ff;
  logic nxt_thr_full;
  logic [7:0] tx_sh_ff;
  logic [7:0] nxt_tx_sh;
  logic tx_par_ff;
  logic nxt_tx_par;
  logic [5:0] tx_cnt_ff;
  logic [5:0] nxt_tx_cnt;
  logic [2:0] tx_idx_ff;
  logic [2:0] nxt_tx_idx;
  logic pin_ff;
  logic nxt_pin;
  logic [5:0] tx_len;
  logic tx_end;
  logic tx_bit;

  // Receive state
  ulf_rx_st_t rx_st_ff;
  ulf_rx_st_t nxt_rx_st;
  ulf_fmt_t rx_fmt_ff;
  ulf_fmt_t nxt_rx_fmt;
  logic [7:0] rx_sh_ff;
  logic [7:0] nxt_rx_sh;
  logic [5:0] rx_cnt_ff;
  logic [5:0] nxt_rx_cnt;
  logic [2:0] rx_idx_ff;
  logic [2:0] nxt_rx_idx;
  logic rx_perr_ff;
  logic nxt_rx_perr;
  logic rx_s1_ff;
  logic rx_s2_ff;
  logic rx_done;
  logic rx_ferr;
  logic rx_mid;

  logic baud_tick;

  ulf_baud_gen #(.WIDTH(16)) u_baud (
    .ref_clk(ref_clk),
    .rst(rst),
    .divisor(nxt_div),
    .reload(div_reload),
    .tick(baud_tick)
  );

  // Zero wait state slave, always OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = hrdata_ff;
  assign serial_tx_pin = pin_ff;
  assign rd_take = hsel && htrans[1] && hready && !hwrite;

  always_comb
  begin
    nxt_lfc = lfc_ff;
    nxt_ier = ier_ff;
    nxt_div = div_ff;
    nxt_rbr = rbr_ff;
    nxt_rdy = rdy_ff;
    nxt_pe = pe_ff;
    nxt_fe = fe_ff;
    nxt_hrdata = hrdata_ff;
    div_reload = 1'b0;
    thr_wr = 1'b0;
    rd_val = 8'h00;
    nxt_wr_pend = hsel && htrans[1] && hready && hwrite;
    nxt_wr_addr = haddr;
    if (wr_pend_ff)
    begin
      case (wr_addr_ff)
        ADDR_DATA:
        begin
          if (lfc_ff.dl_sel)
          begin
            nxt_div[7:0] = hwdata[7:0];
            div_reload = 1'b1;
          end
          else
            thr_wr = 1'b1;
        end
        ADDR_IER:
        begin
          if (lfc_ff.dl_sel)
          begin
            nxt_div[15:8] = hwdata[7:0];
            div_reload = 1'b1;
          end
          else
            nxt_ier = hwdata[3:0];
        end
        ADDR_LFC: nxt_lfc = ulf_fmt_t'(hwdata[7:0]);
        default: nxt_lfc = lfc_ff;
      endcase
    end
    // Read sees a write still in its data phase
    case (haddr)
      ADDR_DATA: rd_val = nxt_lfc.dl_sel ? nxt_div[7:0] : rbr_ff;
      ADDR_IER: rd_val = nxt_lfc.dl_sel ? nxt_div[15:8] : {4'h0, nxt_ier};
      ADDR_LFC: rd_val = nxt_lfc;
      ADDR_STAT:
      begin
        rd_val[ST_RDY] = rdy_ff;
        rd_val[ST_PE] = pe_ff;
        rd_val[ST_FE] = fe_ff;
        rd_val[ST_THRE] = !thr_full_ff;
        rd_val[ST_TEMT] = !thr_full_ff && tx_st_ff == TX_IDLE;
      end
      default: rd_val = 8'h00;
    endcase
    if (rd_take)
    begin
      nxt_hrdata = {24'h000000, rd_val};
      if (haddr == ADDR_DATA && !nxt_lfc.dl_sel)
        nxt_rdy = 1'b0;
      if (haddr == ADDR_STAT)
      begin
        nxt_pe = 1'b0;
        nxt_fe = 1'b0;
      end
    end
    // Set wins over a clear in the same cycle
    if (rx_done)
    begin
      nxt_rbr = rx_sh_ff & ulf_mask(rx_fmt_ff.wlen);
      nxt_rdy = 1'b1;
      nxt_fe = nxt_fe || rx_ferr;
      nxt_pe = nxt_pe || rx_perr_ff;
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      lfc_ff <= ulf_fmt_t'(LFC_RST);
      ier_ff <= IER_RST;
      div_ff <= DIV_RST;
      rbr_ff <= 8'h00;
      rdy_ff <= 1'b0;
      pe_ff <= 1'b0;
      fe_ff <= 1'b0;
      wr_pend_ff <= 1'b0;
      wr_addr_ff <= 8'h00;
      hrdata_ff <= 32'h00000000;
    end
    else
    begin
      lfc_ff <= nxt_lfc;
      ier_ff <= nxt_ier;
      div_ff <= nxt_div;
      rbr_ff <= nxt_rbr;
      rdy_ff <= nxt_rdy;
      pe_ff <= nxt_pe;
      fe_ff <= nxt_fe;
      wr_pend_ff <= nxt_wr_pend;
      wr_addr_ff <= nxt_wr_addr;
      hrdata_ff <= nxt_hrdata;
    end
  end

  // Transmitter
  always_comb
  begin
    case (tx_st_ff)
      TX_STOP:
      begin
        if (!tx_fmt_ff.stop2)
          tx_len = TICKS_BIT;
        else if (tx_fmt_ff.wlen == 2'b00)
          tx_len = TICKS_STOP15;
        else
          tx_len = TICKS_STOP2;
      end
      default: tx_len = TICKS_BIT;
    endcase
    tx_end = baud_tick && tx_cnt_ff == tx_len - 6'h01;
    case (tx_st_ff)
      TX_START: tx_bit = 1'b0;
      TX_DATA: tx_bit = tx_sh_ff[0];
      TX_PAR: tx_bit = tx_par_ff;
      default: tx_bit = 1'b1;
    endcase
    nxt_pin = lfc_ff.brk ? 1'b0 : tx_bit;
    nxt_tx_st = tx_st_ff;
    nxt_tx_fmt = tx_fmt_ff;
    nxt_thr = thr_wr ? hwdata[7:0] : thr_ff;
    nxt_thr_full = thr_full_ff || thr_wr;
    nxt_tx_sh = tx_sh_ff;
    nxt_tx_par = tx_par_ff;
    nxt_tx_idx = tx_idx_ff;
    nxt_tx_cnt = baud_tick ? tx_cnt_ff + 6'h01 : tx_cnt_ff;
    case (tx_st_ff)
      TX_IDLE:
      begin
        nxt_tx_cnt = 6'h00;
        if (thr_full_ff)
        begin
          nxt_tx_fmt = lfc_ff;
          nxt_tx_sh = thr_ff;
          nxt_tx_par = ulf_parity(thr_ff, lfc_ff);
          nxt_thr_full = thr_wr;
          nxt_tx_idx = 3'h0;
          nxt_tx_st = TX_START;
        end
      end
      TX_START:
      begin
        if (tx_end)
        begin
          nxt_tx_cnt = 6'h00;
          nxt_tx_st = TX_DATA;
        end
      end
      TX_DATA:
      begin
        if (tx_end)
        begin
          nxt_tx_cnt = 6'h00;
          nxt_tx_sh = {1'b0, tx_sh_ff[7:1]};
          nxt_tx_idx = tx_idx_ff + 3'h1;
          if (tx_idx_ff == ulf_last_idx(tx_fmt_ff.wlen))
            nxt_tx_st = tx_fmt_ff.par_en ? TX_PAR : TX_STOP;
        end
      end
      TX_PAR:
      begin
        if (tx_end)
        begin
          nxt_tx_cnt = 6'h00;
          nxt_tx_st = TX_STOP;
        end
      end
      TX_STOP:
      begin
        if (tx_end)
        begin
          nxt_tx_cnt = 6'h00;
          nxt_tx_st = TX_IDLE;
        end
      end
      default: nxt_tx_st = TX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      tx_st_ff <= TX_IDLE;
      tx_fmt_ff <= ulf_fmt_t'(LFC_RST);
      thr_ff <= 8'h00;
      thr_full_ff <= 1'b0;
      tx_sh_ff <= 8'h00;
      tx_par_ff <= 1'b0;
      tx_cnt_ff <= 6'h00;
      tx_idx_ff <= 3'h0;
      pin_ff <= 1'b1;
    end
    else
    begin
      tx_st_ff <= nxt_tx_st;
      tx_fmt_ff <= nxt_tx_fmt;
      thr_ff <= nxt_thr;
      thr_full_ff <= nxt_thr_full;
      tx_sh_ff <= nxt_tx_sh;
      tx_par_ff <= nxt_tx_par;
      tx_cnt_ff <= nxt_tx_cnt;
      tx_idx_ff <= nxt_tx_idx;
      pin_ff <= nxt_pin;
    end
  end

  // Receiver; line is synchronised before use
  always_comb
  begin
    nxt_rx_st = rx_st_ff;
    nxt_rx_fmt = rx_fmt_ff;
    nxt_rx_sh = rx_sh_ff;
    nxt_rx_idx = rx_idx_ff;
    nxt_rx_perr = rx_perr_ff;
    nxt_rx_cnt = baud_tick ? rx_cnt_ff + 6'h01 : rx_cnt_ff;
    rx_mid = baud_tick && rx_cnt_ff == TICKS_BIT - 6'h01;
    rx_done = 1'b0;
    rx_ferr = 1'b0;
    case (rx_st_ff)
      RX_IDLE:
      begin
        nxt_rx_cnt = 6'h00;
        if (!rx_s2_ff)
        begin
          nxt_rx_fmt = lfc_ff;
          nxt_rx_sh = 8'h00;
          nxt_rx_idx = 3'h0;
          nxt_rx_perr = 1'b0;
          nxt_rx_st = RX_START;
        end
      end
      RX_START:
      begin
        if (baud_tick && rx_cnt_ff == TICKS_HALF - 6'h01)
        begin
          nxt_rx_cnt = 6'h00;
          nxt_rx_st = rx_s2_ff ? RX_IDLE : RX_DATA;
        end
      end
      RX_DATA:
      begin
        if (rx_mid)
        begin
          nxt_rx_cnt = 6'h00;
          nxt_rx_sh[rx_idx_ff] = rx_s2_ff;
          nxt_rx_idx = rx_idx_ff + 3'h1;
          if (rx_idx_ff == ulf_last_idx(rx_fmt_ff.wlen))
            nxt_rx_st = rx_fmt_ff.par_en ? RX_PAR : RX_STOP;
        end
      end
      RX_PAR:
      begin
        if (rx_mid)
        begin
          nxt_rx_cnt = 6'h00;
          nxt_rx_perr = rx_s2_ff != ulf_parity(rx_sh_ff, rx_fmt_ff);
          nxt_rx_st = RX_STOP;
        end
      end
      RX_STOP:
      begin
        if (rx_mid)
        begin
          rx_done = 1'b1;
          rx_ferr = !rx_s2_ff;
          nxt_rx_st = RX_IDLE;
        end
      end
      default: nxt_rx_st = RX_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      rx_s1_ff <= 1'b1;
      rx_s2_ff <= 1'b1;
      rx_st_ff <= RX_IDLE;
      rx_fmt_ff <= ulf_fmt_t'(LFC_RST);
      rx_sh_ff <= 8'h00;
      rx_cnt_ff <= 6'h00;
      rx_idx_ff <= 3'h0;
      rx_perr_ff <= 1'b0;
    end
    else
    begin
      rx_s1_ff <= serial_rx_pin;
      rx_s2_ff <= rx_s1_ff;
      rx_st_ff <= nxt_rx_st;
      rx_fmt_ff <= nxt_rx_fmt;
      rx_sh_ff <= nxt_rx_sh;
      rx_cnt_ff <= nxt_rx_cnt;
      rx_idx_ff <= nxt_rx_idx;
      rx_perr_ff <= nxt_rx_perr;
    end
  end

  property p_brk;
    @(posedge ref_clk) disable iff (rst)
    lfc_ff.brk |=> !serial_tx_pin;
  endproperty
  a_brk: assert property (p_brk) else $error("Break did not hold line low");

  property p_brk_runs;
    @(posedge ref_clk) disable iff (rst)
    lfc_ff.brk && tx_st_ff == TX_IDLE && thr_full_ff |=> tx_st_ff == TX_START;
  endproperty
  a_brk_runs: assert property (p_brk_runs) else $error("Break stalled transmitter");

  property p_idle_mark;
    @(posedge ref_clk) disable iff (rst)
    tx_st_ff == TX_IDLE && !lfc_ff.brk |=> serial_tx_pin;
  endproperty
  a_idle_mark: assert property (p_idle_mark) else $error("Idle line not high");

  property p_lsb_first;
    @(posedge ref_clk) disable iff (rst)
    tx_st_ff == TX_DATA && tx_idx_ff == 3'h0 && !lfc_ff.brk |=> serial_tx_pin == $past(tx_sh_ff[0]);
  endproperty
  a_lsb_first: assert property (p_lsb_first) else $error("Data bit order wrong");

  property p_stick_zero;
    @(posedge ref_clk) disable iff (rst)
    tx_st_ff == TX_PAR && tx_fmt_ff.stick && tx_fmt_ff.even && !lfc_ff.brk |=> !serial_tx_pin;
  endproperty
  a_stick_zero: assert property (p_stick_zero) else $error("Fixed parity not zero");

  property p_fmt_hold;
    @(posedge ref_clk) disable iff (rst)
    tx_st_ff != TX_IDLE |=> $stable(tx_fmt_ff);
  endproperty
  a_fmt_hold: assert property (p_fmt_hold) else $error("Format changed mid character");

  property p_lfc_read;
    @(posedge ref_clk) disable iff (rst)
    rd_take && haddr == ADDR_LFC && !wr_pend_ff |=> hrdata[7:0] == $past(lfc_ff);
  endproperty
  a_lfc_read: assert property (p_lfc_read) else $error("Format register read back wrong");

  property p_one_stop;
    @(posedge ref_clk) disable iff (rst)
    rx_st_ff == RX_STOP && rx_mid |=> rx_st_ff == RX_IDLE;
  endproperty
  a_one_stop: assert property (p_one_stop) else $error("Receiver waited past first stop");

endmodule

//--- tb/ulf_remote.sv
`timescale 1ns/1ps
module ulf_remote (
  input wire logic ref_clk,
  input wire logic line_in,
  output logic line_out
);
  int cyc = 0;

  initial line_out = 1'b1;

  always @(posedge ref_clk)
    cyc <= cyc + 1;

  task automatic hold(input int n);
    repeat (n) @(posedge ref_clk);
  endtask

  // Sends one frame, marking level afterwards
  task automatic send(input logic [7:0] d, input int nb, input logic pe, input logic par, input logic stp,
                      input int dv);
    line_out <= 1'b0;
    hold(16 * dv);
    for (int i = 0; i < nb; i++)
    begin
      line_out <= d[i];
      hold(16 * dv);
    end
    if (pe)
    begin
      line_out <= par;
      hold(16 * dv);
    end
    line_out <= stp;
    hold(16 * dv);
    line_out <= 1'b1;
  endtask

  // Samples one frame at mid-bit, start edge time in t0
  task automatic recv(input int nb, input logic pe, input int dv, output logic [7:0] d, output logic par,
                      output logic stp, output int t0, output logic st0);
    d = 8'h00;
    par = 1'b0;
    while (line_in !== 1'b0)
      @(posedge ref_clk);
    t0 = cyc;
    hold(8 * dv);
    st0 = line_in;
    for (int i = 0; i < nb; i++)
    begin
      hold(16 * dv);
      d[i] = line_in;
    end
    if (pe)
    begin
      hold(16 * dv);
      par = line_in;
    end
    hold(16 * dv);
    stp = line_in;
  endtask
endmodule

//--- tb/ulf_uart_core_tb.sv
`timescale 1ns/1ps
module ulf_uart_core_tb
  import ulf_pkg::*;
;
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic hsel = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic serial_rx_pin;
  logic serial_tx_pin;
  logic [31:0] lfsr = 32'h67f433bc;
  int err_total = 0;
  int n_tests = 0;
  int dv = 2;

  always #5 ref_clk = ~ref_clk;

  ulf_uart_core u_dut (
    .ref_clk(ref_clk),
    .rst(rst),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .serial_rx_pin(serial_rx_pin),
    .serial_tx_pin(serial_tx_pin)
  );

  ulf_remote u_far (
    .ref_clk(ref_clk),
    .line_in(serial_tx_pin),
    .line_out(serial_rx_pin)
  );

  function automatic logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction

  function automatic logic exp_par(input logic [7:0] d, input logic [7:0] f);
    if (f[5])
      return ~f[4];
    return (^(d & (8'hff >> (3 - f[1:0])))) ^ ~f[4];
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_total++;
      $display("mismatch at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  // Single AHB-Lite word transfer
  task automatic bus(input logic wr, input logic [7:0] a, input logic [7:0] d, output logic [31:0] q);
    @(posedge ref_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr <= a;
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge ref_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask

  task automatic results();
    if (err_total == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    repeat (90000) @(posedge ref_clk);
    err_total++;
    $display("mismatch at %0t: timeout", $time);
    results();
  end

  initial
  begin
    logic [31:0] q;
    logic [31:0] r;
    logic [7:0] f;
    logic [7:0] d0;
    logic [7:0] d1;
    logic [7:0] g0;
    logic [7:0] g1;
    logic [7:0] m;
    logic p0, p1, s0, s1, b0, b1, pe, par;
    int t0, t1, nb, pm, sl;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    bus(1'b0, ADDR_LFC, 8'h00, q);
    chk(q, 32'h3, "format reset");
    chk(serial_tx_pin, 1'b1, "idle level");
    chk(hresp, 1'b0, "response");
    bus(1'b1, 8'h1c, 8'ha5, q);
    bus(1'b0, 8'h1c, 8'h00, q);
    chk(q, 32'h0, "unmapped");
    for (int i = 0; i < 6; i++)
    begin
      r = rnd();
      r[7:0] = (i == 4) ? 8'hff : (i == 5) ? 8'h00 : r[7:0];
      bus(1'b1, ADDR_LFC, r[7:0], q);
      bus(1'b0, ADDR_LFC, 8'h00, q);
      chk(q, {24'h0, r[7:0]}, "format readback");
    end
    // Random divisor, then back to 2 through both bytes
    bus(1'b1, ADDR_LFC, 8'h83, q);
    r = rnd();
    r[1] = 1'b1;
    bus(1'b1, ADDR_DATA, r[7:0], q);
    bus(1'b1, ADDR_IER, r[15:8], q);
    bus(1'b0, ADDR_DATA, 8'h00, q);
    chk(q, {24'h0, r[7:0]}, "divisor low");
    bus(1'b0, ADDR_IER, 8'h00, q);
    chk(q, {24'h0, r[15:8]}, "divisor high");
    bus(1'b1, ADDR_LFC, 8'h03, q);
    bus(1'b1, ADDR_IER, 8'h0a, q);
    bus(1'b0, ADDR_IER, 8'h00, q);
    chk(q, 32'h0a, "enable reg");
    bus(1'b1, ADDR_LFC, 8'h83, q);
    bus(1'b0, ADDR_IER, 8'h00, q);
    chk(q, {24'h0, r[15:8]}, "divisor kept");
    bus(1'b1, ADDR_DATA, 8'h02, q);
    bus(1'b1, ADDR_IER, 8'h00, q);
    for (int k = 0; k < 20; k++)
    begin
      pm = k / 4;
      pe = (pm != 0);
      f = {2'b00, pm >= 3, pm == 2 || pm == 4, pe, pm[0], k[1:0]};
      nb = 5 + k % 4;
      m = 8'hff >> (3 - k % 4);
      if (k == 19)
      begin
        dv = 3;
        bus(1'b1, ADDR_LFC, 8'h80, q);
        bus(1'b1, ADDR_DATA, 8'h03, q);
      end
      bus(1'b1, ADDR_LFC, f, q);
      r = rnd();
      d0 = (k == 0) ? 8'hff : r[7:0];
      d1 = r[15:8];
      fork
        begin
          u_far.recv(nb, pe, dv, g0, p0, s0, t0, b0);
          u_far.recv(nb, pe, dv, g1, p1, s1, t1, b1);
        end
        begin
          bus(1'b1, ADDR_DATA, d0, q);
          bus(1'b1, ADDR_DATA, d1, q);
        end
      join
      chk(b0, 1'b0, "start bit");
      chk(g0, d0 & m, "tx data");
      chk(g1, d1 & m, "tx data");
      chk(p0, pe & exp_par(d0, f), "tx parity");
      chk(p1, pe & exp_par(d1, f), "tx parity");
      chk(s0, 1'b1, "stop level");
      sl = f[2] ? ((f[1:0] == 2'b00) ? 24 : 32) : 16;
      t1 = t1 - t0 - (1 + nb + pe) * 16 * dv - sl * dv;
      chk(t1 >= -2 && t1 <= dv + 3, 1'b1, "frame length");
      par = exp_par(d0, f);
      u_far.send(d0, nb, pe, (k == 5) ? ~par : par, k != 3, dv);
      repeat (4 * dv) @(posedge ref_clk);
      bus(1'b0, ADDR_STAT, 8'h00, q);
      chk(q[ST_RDY], 1'b1, "rx ready");
      chk(q[ST_PE], k == 5, "parity check");
      chk(q[ST_FE], k == 3, "framing check");
      bus(1'b0, ADDR_DATA, 8'h00, q);
      chk(q, {24'h0, d0 & m}, "rx data");
    end
    // Format change in mid-character
    bus(1'b1, ADDR_LFC, 8'h03, q);
    r = rnd();
    fork
      u_far.recv(8, 1'b0, dv, g0, p0, s0, t0, b0);
      begin
        bus(1'b1, ADDR_DATA, r[7:0], q);
        bus(1'b1, ADDR_LFC, 8'h00, q);
      end
    join
    chk(g0, r[7:0], "format boundary");
    bus(1'b1, ADDR_DATA, 8'h55, q);
    bus(1'b1, ADDR_LFC, 8'h43, q);
    for (int i = 0; i < 8; i++)
    begin
      repeat (32 * dv) @(posedge ref_clk);
      chk(serial_tx_pin, 1'b0, "break level");
    end
    bus(1'b0, ADDR_STAT, 8'h00, q);
    chk(q[ST_TEMT], 1'b1, "tx ran under break");
    bus(1'b1, ADDR_LFC, 8'h03, q);
    repeat (2) @(posedge ref_clk);
    chk(serial_tx_pin, 1'b1, "break released");
    results();
  end
endmodule
